// *** rtl/pwr_seq_pkg.sv ***
// constants, types and register map of the power and reset sequencer
// ----------------------------------------------------------------------
// Summary of operation
// - enable low: sleep, regulator off, logic idle
// - enable high, bias good: start regulator now
// - enable falls, bias good: outputs off at once
// - bias or regulator undervoltage: reset to defaults
// - each reset pass sets power-up and error flags
// - reset state: outputs off, fault pin low
// - supplies good: go to init, release fault pin
// - init timer from stored delay, then normal
// - clear power-up in init: skip to normal
// - power-up copies stored settings, channels off
// - reload command reloads settings, clears power-up flag
// - clear power-up command clears flag in init or normal
// - output supply undervoltage: outputs off, flags set
// - below low threshold sets warning and error
// - clear faults clears warning with other faults
// - warning assertion clears LED open, short faults
// - below threshold suppresses open and short detection
// - threshold code 5 bits, 4V to 35V
// - low supply warning deglitched about 96 us
// - supply undervoltage shutdown deglitched about 96 us
// ----------------------------------------------------------------------
package pwr_seq_pkg;

  // ----------------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------------
  localparam int CLK_MHZ         = 250;
  localparam int DEGLITCH_US     = 96;
  localparam int DEGLITCH_CYC    = DEGLITCH_US * CLK_MHZ;
  localparam int INIT_STEP_CYC   = 2500;

  // ----------------------------------------------------------------------
  // register map, byte addresses
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_CMD       = 8'h00;
  localparam logic [7:0] ADDR_THRESH    = 8'h04;
  localparam logic [7:0] ADDR_CHAN_EN   = 8'h08;
  localparam logic [7:0] ADDR_STATUS    = 8'h0c;
  localparam logic [7:0] ADDR_LED_OPEN  = 8'h10;
  localparam logic [7:0] ADDR_LED_SHORT = 8'h14;

  // command bits, write one to act, read as zero
  localparam int CMD_CLR_POWER_UP = 0;
  localparam int CMD_RELOAD       = 1;
  localparam int CMD_CLR_FAULTS   = 2;

  // threshold code: volts = code + THRESH_BASE_V
  localparam int         THRESH_W      = 5;
  localparam int         THRESH_BASE_V = 4;
  localparam int         CHANNELS      = 16;
  localparam logic [15:0] CHAN_EN_RST  = 16'h0000;

  // ----------------------------------------------------------------------
  // types
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_SLEEP  = 4'b0001,
    ST_RESET  = 4'b0010,
    ST_INIT   = 4'b0100,
    ST_NORMAL = 4'b1000
  } state_t;

  typedef struct packed {
    logic power_up;
    logic err;
    logic supply_uv;
    logic low_supply;
  } flags_t;

  localparam flags_t FLAGS_RST = '{power_up: 1'b1, err: 1'b1,
                                   supply_uv: 1'b0, low_supply: 1'b0};

endpackage

// *** rtl/power_reset_supply_monitor.sv ***
// power, reset sequencing and supply monitor of the led driver
//
// Decided for this implementation: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
module power_reset_supply_monitor
  import pwr_seq_pkg::*;
#(
  parameter int DEGLITCH      = DEGLITCH_CYC,
  parameter int INIT_CODE_W   = 4,
  parameter int INIT_STEP     = INIT_STEP_CYC
) (
  // clock and reset
  input  wire logic                   clock,
  input  wire logic                   rst,
  // analog status pins
  input  wire logic                   en,
  input  wire logic                   vbat_ok,
  input  wire logic                   ldo_ok,
  input  wire logic                   supply_uv,
  input  wire logic                   supply_low,
  // stored non-volatile settings
  input  wire logic [INIT_CODE_W-1:0] init_delay_setting,
  input  wire logic [THRESH_W-1:0]    nv_low_supply_threshold,
  // led diagnostics, same clock
  input  wire logic [CHANNELS-1:0]    led_open_det,
  input  wire logic [CHANNELS-1:0]    led_short_det,
  // register port
  input  wire logic [7:0]             addr,
  input  wire logic [31:0]            wdata,
  input  wire logic                   wr,
  input  wire logic                   rd,
  output logic      [31:0]            rdata,
  // controls toward the analog side
  output logic                        regulator_enable,
  output logic      [CHANNELS-1:0]    channel_on,
  output logic                        diag_enable,
  output logic      [THRESH_W-1:0]    low_supply_threshold,
  output logic      [7:0]             low_supply_volts,
  // open-drain fault pin
  input  wire logic                   err_i,
  output logic                        err_o,
  output logic                        err_oe
);

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  localparam int DW = $clog2(DEGLITCH + 1);

  function automatic logic [23:0] init_len(
    input logic [INIT_CODE_W-1:0] code);
    init_len = 24'((int'(code) + 1) * INIT_STEP);
  endfunction

  function automatic logic wr_hit(input logic [7:0] a, input logic w,
                                  input logic [7:0] off);
    wr_hit = w && (a == off);
  endfunction

  // ----------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------
  logic [5:0] sync1_ff;
  logic [5:0] sync2_ff;
  logic       en_s;
  logic       vbat_s;
  logic       ldo_s;
  logic       uv_s;
  logic       low_s;
  logic       err_pin_s;

  // async pins get two flops before anything looks at them
  always_ff @(posedge clock) begin
    if (rst) begin
      sync1_ff <= 6'h00;
      sync2_ff <= 6'h00;
    end else begin
      sync1_ff <= {err_i, supply_low, supply_uv, ldo_ok, vbat_ok, en};
      sync2_ff <= sync1_ff;
    end
  end

  assign en_s      = sync2_ff[0];
  assign vbat_s    = sync2_ff[1];
  assign ldo_s     = sync2_ff[2];
  assign uv_s      = sync2_ff[3];
  assign low_s     = sync2_ff[4];
  assign err_pin_s = sync2_ff[5];

  // ----------------------------------------------------------------------
  // deglitch filters: 0 = output supply uv, 1 = low supply
  // ----------------------------------------------------------------------
  logic [1:0] raw_cond;
  logic [1:0] flt;

  assign raw_cond = {low_s, uv_s};

  for (genvar g = 0; g < 2; g++) begin : g_deg
    logic [DW-1:0] cnt_ff;
    logic [DW-1:0] nxt_cnt;
    logic          flt_ff;
    logic          nxt_flt;

    // a short dip restarts the count; release is immediate
    always_comb begin
      nxt_cnt = cnt_ff;
      nxt_flt = flt_ff;
      if (!raw_cond[g]) begin
        nxt_cnt = '0;
        nxt_flt = 1'b0;
      end else if (cnt_ff == DW'(DEGLITCH - 1)) begin
        nxt_flt = 1'b1;
      end else begin
        nxt_cnt = cnt_ff + DW'(1);
      end
    end

    always_ff @(posedge clock) begin
      if (rst) begin
        cnt_ff <= '0;
        flt_ff <= 1'b0;
      end else begin
        cnt_ff <= nxt_cnt;
        flt_ff <= nxt_flt;
      end
    end

    assign flt[g] = flt_ff;
  end

  // ----------------------------------------------------------------------
  // sequencing state and init timer
  // ----------------------------------------------------------------------
  state_t      state_ff;
  state_t      nxt_state;
  logic [23:0] timer_ff;
  logic [23:0] nxt_timer;
  logic        por_cond;
  logic        clr_pu;
  logic        init_done;

  assign init_done = (timer_ff == init_len(init_delay_setting) - 24'h1);
  assign por_cond = !vbat_s || !ldo_s;
  assign clr_pu   = wr_hit(addr, wr, ADDR_CMD) && wdata[CMD_CLR_POWER_UP];

  always_comb begin
    nxt_state = state_ff;
    nxt_timer = 24'h000000;
    if (!en_s) begin
      nxt_state = ST_SLEEP;
    end else if (por_cond) begin
      nxt_state = ST_RESET;
    end else begin
      case (state_ff)
        ST_SLEEP:  nxt_state = ST_RESET;
        ST_RESET:  nxt_state = ST_INIT;
        ST_INIT: begin
          if (clr_pu) begin
            nxt_state = ST_NORMAL;
          end else if (init_done) begin
            nxt_state = ST_NORMAL;
          end else begin
            nxt_timer = timer_ff + 24'h1;
          end
        end
        ST_NORMAL: nxt_state = ST_NORMAL;
        default:   nxt_state = ST_RESET;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state_ff <= ST_RESET;
      timer_ff <= 24'h000000;
    end else begin
      state_ff <= nxt_state;
      timer_ff <= nxt_timer;
    end
  end

  // ----------------------------------------------------------------------
  // registers and flags
  // ----------------------------------------------------------------------
  flags_t                flags_ff;
  flags_t                nxt_flags;
  logic [THRESH_W-1:0]   thresh_ff;
  logic [THRESH_W-1:0]   nxt_thresh;
  logic [CHANNELS-1:0]   chan_en_ff;
  logic [CHANNELS-1:0]   nxt_chan_en;
  logic [CHANNELS-1:0]   open_ff;
  logic [CHANNELS-1:0]   nxt_open;
  logic [CHANNELS-1:0]   short_ff;
  logic [CHANNELS-1:0]   nxt_short;
  logic                  low_prev_ff;
  logic                  in_por;
  logic                  reload;
  logic                  clr_flt;
  logic                  low_rise;

  // sleep counts as reset: the core is unpowered there
  assign in_por   = (state_ff == ST_RESET) || (state_ff == ST_SLEEP);
  assign reload   = wr_hit(addr, wr, ADDR_CMD) && wdata[CMD_RELOAD];
  assign clr_flt  = wr_hit(addr, wr, ADDR_CMD) && wdata[CMD_CLR_FAULTS];
  assign low_rise = flt[1] && !low_prev_ff;

  always_comb begin
    nxt_flags   = flags_ff;
    nxt_thresh  = thresh_ff;
    nxt_chan_en = chan_en_ff;
    nxt_open    = open_ff;
    nxt_short   = short_ff;
    if (in_por) begin
      nxt_flags   = FLAGS_RST;
      nxt_thresh  = nv_low_supply_threshold;
      nxt_chan_en = CHAN_EN_RST;
      nxt_open    = '0;
      nxt_short   = '0;
    end else begin
      if (reload) begin
        nxt_thresh     = nv_low_supply_threshold;
        nxt_chan_en    = CHAN_EN_RST;
        nxt_open       = '0;
        nxt_short      = '0;
        nxt_flags.power_up = 1'b0;
      end else begin
        if (wr_hit(addr, wr, ADDR_THRESH)) begin
          nxt_thresh = wdata[THRESH_W-1:0];
        end
        if (wr_hit(addr, wr, ADDR_CHAN_EN)) begin
          nxt_chan_en = wdata[CHANNELS-1:0];
        end
      end
      if (clr_pu) begin
        nxt_flags.power_up = 1'b0;
      end
      if (clr_flt) begin
        nxt_flags.supply_uv  = 1'b0;
        nxt_flags.low_supply = 1'b0;
        nxt_flags.err        = 1'b0;
        nxt_open             = '0;
        nxt_short            = '0;
      end
      // detections win over a clear in the same cycle
      if (low_rise) begin
        nxt_open  = '0;
        nxt_short = '0;
      end else if (!low_s) begin
        nxt_open  = nxt_open | led_open_det;
        nxt_short = nxt_short | led_short_det;
      end
      if (flt[0]) begin
        nxt_flags.supply_uv = 1'b1;
        nxt_flags.err       = 1'b1;
      end
      if (flt[1]) begin
        nxt_flags.low_supply = 1'b1;
        nxt_flags.err        = 1'b1;
      end
      if (nxt_flags.power_up) begin
        nxt_flags.err = 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      flags_ff    <= FLAGS_RST;
      thresh_ff   <= '0;
      chan_en_ff  <= CHAN_EN_RST;
      open_ff     <= '0;
      short_ff    <= '0;
      low_prev_ff <= 1'b0;
    end else begin
      flags_ff    <= nxt_flags;
      thresh_ff   <= nxt_thresh;
      chan_en_ff  <= nxt_chan_en;
      open_ff     <= nxt_open;
      short_ff    <= nxt_short;
      low_prev_ff <= flt[1];
    end
  end

  // ----------------------------------------------------------------------
  // outputs toward the analog side
  // ----------------------------------------------------------------------
  logic [CHANNELS-1:0] nxt_chan_on;
  logic                nxt_err_oe;
  logic                nxt_reg_en;
  logic                nxt_diag;

  always_comb begin
    nxt_reg_en  = en_s && vbat_s;
    nxt_chan_on = '0;
    if ((state_ff == ST_NORMAL) && en_s && !flt[0] && !por_cond) begin
      nxt_chan_on = chan_en_ff;
    end
    nxt_err_oe = (state_ff == ST_RESET) || flt[0];
    nxt_diag   = (state_ff == ST_NORMAL) && !low_s;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      regulator_enable <= 1'b0;
      channel_on       <= '0;
      err_oe           <= 1'b1;
      diag_enable      <= 1'b0;
    end else begin
      regulator_enable <= nxt_reg_en;
      channel_on       <= nxt_chan_on;
      err_oe           <= nxt_err_oe;
      diag_enable      <= nxt_diag;
    end
  end

  // pin is only ever pulled low
  assign err_o                = 1'b0;
  assign low_supply_threshold = thresh_ff;
  assign low_supply_volts     = 8'(thresh_ff) + 8'(THRESH_BASE_V);

  // ----------------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------------
  logic [31:0] nxt_rdata;

  always_comb begin
    nxt_rdata = 32'h00000000;
    if (rd) begin
      case (addr)
        ADDR_THRESH:    nxt_rdata = 32'(thresh_ff);
        ADDR_CHAN_EN:   nxt_rdata = 32'(chan_en_ff);
        ADDR_STATUS:    nxt_rdata = 32'({err_pin_s, state_ff, flags_ff});
        ADDR_LED_OPEN:  nxt_rdata = 32'(open_ff);
        ADDR_LED_SHORT: nxt_rdata = 32'(short_ff);
        default:        nxt_rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      rdata <= 32'h00000000;
    end else begin
      rdata <= nxt_rdata;
    end
  end

endmodule

// *** tb/supply_host_model.sv ***
// far-side model: enable pin, supply monitors, pulled-up fault line
`timescale 1ns/1ps
module supply_host_model (
  // clock
  input  wire logic       clock,
  // wanted levels {low, uv, ldo, vbat, en}
  input  wire logic [4:0] want,
  // open-drain fault line
  input  wire logic       err_o,
  input  wire logic       err_oe,
  output logic            err_pin,
  // monitor levels
  output logic            en,
  output logic            vbat_ok,
  output logic            ldo_ok,
  output logic            supply_uv,
  output logic            supply_low
);
  // ----------------------------------------------------------------------
  // levels
  // ----------------------------------------------------------------------
  // comparators move only right after an edge, never on it
  logic [4:0] lvl_ff = 5'h07;
  always @(posedge clock) begin
    lvl_ff <= want;
  end
  assign {supply_low, supply_uv, ldo_ok, vbat_ok, en} = lvl_ff;
  // a released line floats up to the pull-up, not to its last value
  assign err_pin = err_oe ? err_o : 1'b1;
endmodule

// *** tb/supply_seq_monitor.sv ***
// concurrent checks of the power and reset sequencer
`timescale 1ns/1ps
module supply_seq_checker
  import pwr_seq_pkg::*;
#(
  parameter int DEGLITCH = DEGLITCH_CYC
) (
  // clock and reset
  input wire logic                clock,
  input wire logic                rst,
  // pins
  input wire logic                en,
  input wire logic                vbat_ok,
  input wire logic                ldo_ok,
  input wire logic                supply_uv,
  input wire logic                supply_low,
  // outputs
  input wire logic                regulator_enable,
  input wire logic [CHANNELS-1:0] channel_on,
  input wire logic                diag_enable,
  input wire logic [THRESH_W-1:0] low_supply_threshold,
  input wire logic [7:0]          low_supply_volts,
  input wire logic                err_o,
  input wire logic                err_oe
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // ----------------------------------------------------------------------
  // run length of undervoltage, saturating
  // ----------------------------------------------------------------------
  logic [15:0] uv_run_ff;
  logic [15:0] nxt_uv_run;
  always_comb begin
    nxt_uv_run = 16'h0000;
    if (supply_uv) begin
      nxt_uv_run = (&uv_run_ff) ? uv_run_ff : uv_run_ff + 16'h0001;
    end
  end
  always_ff @(posedge clock) begin
    uv_run_ff <= nxt_uv_run;
  end
  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  sleep_reg_off_a: assert property (
    !en [*4] |-> !regulator_enable) else $error("regulator on in sleep");
  reg_start_a: assert property (
    (en && vbat_ok) [*4] |-> regulator_enable) else $error("regulator off");
  en_off_a: assert property (
    !en [*4] |-> channel_on == '0) else $error("outputs on with enable low");
  por_hold_a: assert property (
    (en && !(vbat_ok && ldo_ok)) [*5] |-> channel_on == '0 && err_oe)
    else $error("reset state not holding outputs and fault pin");
  init_release_a: assert property (
    (en && vbat_ok && ldo_ok && !supply_uv) [*8] |-> !err_oe)
    else $error("fault pin held with supplies good");
  uv_shut_a: assert property (
    32'(uv_run_ff) > DEGLITCH + 4 |-> channel_on == '0 && err_oe)
    else $error("no shutdown on output undervoltage");
  diag_off_a: assert property (
    supply_low [*4] |-> !diag_enable) else $error("detection on in low supply");
  volts_map_a: assert property (
    low_supply_volts == 8'(low_supply_threshold) + 8'h04)
    else $error("threshold volts mismatch");
  drain_only_a: assert property (
    err_o == 1'b0) else $error("fault pin driven high");
  cover property (supply_low [*8]);
  cover property ($fell(err_oe));
  cover property (32'(uv_run_ff) == DEGLITCH + 6);
endmodule

bind power_reset_supply_monitor supply_seq_checker #(.DEGLITCH(DEGLITCH)) chk_u (
  .clock(clock), .rst(rst), .en(en), .vbat_ok(vbat_ok), .ldo_ok(ldo_ok),
  .supply_uv(supply_uv), .supply_low(supply_low),
  .regulator_enable(regulator_enable), .channel_on(channel_on),
  .diag_enable(diag_enable), .low_supply_threshold(low_supply_threshold),
  .low_supply_volts(low_supply_volts), .err_o(err_o), .err_oe(err_oe));

// *** tb/power_reset_supply_monitor_test.sv ***
// self-checking bench of the power and reset sequencer
`timescale 1ns/1ps
module power_reset_supply_monitor_test;
  import pwr_seq_pkg::*;
  localparam int DG = 8;
  logic        clock     = 1'b0;
  logic        rst       = 1'b1;
  logic [4:0]  ctl       = 5'h07;
  logic [15:0] open_det  = 16'h0000;
  logic [15:0] short_det = 16'h0000;
  logic [3:0]  init_code = 4'hf;
  logic [7:0]  addr      = 8'h00;
  logic [31:0] wdata     = 32'h0;
  logic        wr        = 1'b0;
  logic        rd        = 1'b0;
  logic        en, vbat_ok, ldo_ok, supply_uv, supply_low, err_pin;
  logic        reg_en, diag_en, err_o, err_oe;
  logic [31:0] rdata;
  logic [15:0] chan_on;
  logic [4:0]  thr;
  logic [7:0]  volts;
  int          fails     = 0;
  int          cmp_count = 0;

  initial forever #2 clock = ~clock;

  supply_host_model env_u (.clock(clock), .want(ctl), .err_o(err_o),
    .err_oe(err_oe), .err_pin(err_pin), .en(en), .vbat_ok(vbat_ok),
    .ldo_ok(ldo_ok), .supply_uv(supply_uv), .supply_low(supply_low));

  power_reset_supply_monitor #(.DEGLITCH(DG), .INIT_CODE_W(4),
    .INIT_STEP(2)) dut_u (.clock(clock), .rst(rst), .en(en),
    .vbat_ok(vbat_ok), .ldo_ok(ldo_ok), .supply_uv(supply_uv),
    .supply_low(supply_low), .init_delay_setting(init_code),
    .nv_low_supply_threshold(5'h0a), .led_open_det(open_det),
    .led_short_det(short_det), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .regulator_enable(reg_en),
    .channel_on(chan_on), .diag_enable(diag_en),
    .low_supply_threshold(thr), .low_supply_volts(volts),
    .err_i(err_pin), .err_o(err_o), .err_oe(err_oe));

  // ----------------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic pins(input logic [4:0] v);
    @(posedge clock);
    ctl <= v;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1 chk(rdata, exp);
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // a hang ends the run as a failure
  initial begin
    step(50000);
    fails++;
    report_and_stop();
  end

  // ----------------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------------
  initial begin
    step(20);
    rst <= 1'b0;
    step(10);
    rd_reg(ADDR_STATUS, 32'h14c);
    step(21);
    // init runs (code + 1) * step cycles: still init here, normal next
    rd_reg(ADDR_STATUS, 32'h14c);
    rd_reg(ADDR_STATUS, 32'h18c);
    wr_reg(ADDR_CMD, 32'h1);
    rd_reg(ADDR_STATUS, 32'h184);
    rd_reg(ADDR_THRESH, 32'h0a);
    for (int i = 0; i < 32; i++) begin
      wr_reg(ADDR_THRESH, 32'(i));
      #1 chk({24'h0, volts}, 32'(i + 4));
      chk({27'h0, thr}, 32'(i));
    end
    wr_reg(ADDR_CHAN_EN, 32'ha5a5);
    step(2);
    #1 chk({16'h0, chan_on}, 32'ha5a5);
    wr_reg(ADDR_CMD, 32'h2);
    rd_reg(ADDR_THRESH, 32'h0a);
    rd_reg(ADDR_CHAN_EN, 32'h0);
    rd_reg(ADDR_CMD, 32'h0);
    wr_reg(ADDR_CMD, 32'h4);
    rd_reg(ADDR_STATUS, 32'h180);
    $display("test registers done");
    wr_reg(ADDR_CHAN_EN, 32'h00ff);
    @(posedge clock) open_det <= 16'h0003;
    @(posedge clock) open_det <= 16'h0000;
    rd_reg(ADDR_LED_OPEN, 32'h3);
    pins(5'h17);
    step(DG - 4);
    pins(5'h07);
    step(4);
    rd_reg(ADDR_STATUS, 32'h180);
    pins(5'h17);
    step(DG + 8);
    rd_reg(ADDR_STATUS, 32'h185);
    rd_reg(ADDR_LED_OPEN, 32'h0);
    @(posedge clock) short_det <= 16'h0010;
    @(posedge clock) short_det <= 16'h0000;
    rd_reg(ADDR_LED_SHORT, 32'h0);
    chk({31'h0, diag_en}, 32'h0);
    pins(5'h07);
    step(4);
    wr_reg(ADDR_CMD, 32'h4);
    rd_reg(ADDR_STATUS, 32'h180);
    chk({31'h0, diag_en}, 32'h1);
    $display("test low supply done");
    pins(5'h0f);
    step(DG + 8);
    #1 chk({16'h0, chan_on}, 32'h0);
    rd_reg(ADDR_STATUS, 32'h086);
    pins(5'h07);
    step(4);
    wr_reg(ADDR_CMD, 32'h4);
    step(2);
    #1 chk({16'h0, chan_on}, 32'h00ff);
    $display("test undervoltage done");
    pins(5'h06);
    step(6);
    #1 chk({31'h0, reg_en}, 32'h0);
    chk({16'h0, chan_on}, 32'h0);
    // regulator output low, bias good: reset state with regulator on
    pins(5'h03);
    step(8);
    rd_reg(ADDR_STATUS, 32'h02c);
    chk({31'h0, reg_en}, 32'h1);
    pins(5'h07);
    step(10);
    rd_reg(ADDR_STATUS, 32'h14c);
    wr_reg(ADDR_CMD, 32'h1);
    rd_reg(ADDR_STATUS, 32'h184);
    $display("test sequencing done");
    // shorter stored delay: code 1 gives four init cycles
    pins(5'h06);
    init_code <= 4'h1;
    step(6);
    pins(5'h07);
    step(7);
    rd_reg(ADDR_STATUS, 32'h14c);
    rd_reg(ADDR_STATUS, 32'h18c);
    $display("test init delay done");
    report_and_stop();
  end
endmodule
